// >>> rtl/ietu_pkg.sv
package ietu_pkg;

  localparam int NSRC      = 20;
  localparam int NCHAN     = 8;
  localparam int PRIO_W    = 4;
  localparam int NUM_W     = 7;
  localparam int VEC_W     = 9;
  localparam int ADDR_W    = 16;
  localparam int CNT_W     = 8;
  localparam int NEXT      = 7;
  localparam int CHAN_W    = 3;

  // Latency bounds in CPU clocks, internal program execution
  localparam int LAT_MIN_CLK = 5;
  localparam int LAT_MAX_CLK = 12;

  // Request numbers
  localparam logic [NUM_W-1:0] NUM_RESET = 7'h00;
  localparam logic [NUM_W-1:0] NUM_NMI   = 7'h02;
  localparam logic [NUM_W-1:0] NUM_STO   = 7'h04;
  localparam logic [NUM_W-1:0] NUM_STU   = 7'h06;
  localparam logic [NUM_W-1:0] NUM_CLSB  = 7'h0A;

  // Exception flag bit positions
  localparam int EXF_NMI  = 0;
  localparam int EXF_STO  = 1;
  localparam int EXF_STU  = 2;
  localparam int EXF_UND  = 3;
  localparam int EXF_PRT  = 4;
  localparam int EXF_OPA  = 5;
  localparam int EXF_INA  = 6;
  localparam int EXF_BUS  = 7;
  localparam int EXF_W    = 8;
  localparam int CLSB_LO  = 3;

  // Edge select codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Source numbers per node
  localparam logic [NSRC*NUM_W-1:0] SRC_NUM = {
    7'h2F, 7'h2E, 7'h2D, 7'h2C, 7'h2B, 7'h47, 7'h2A, 7'h27, 7'h26, 7'h25,
    7'h24, 7'h23, 7'h22, 7'h1F, 7'h1E, 7'h1D, 7'h1C, 7'h1B, 7'h1A, 7'h19};

  typedef struct packed {
    logic              enable;
    logic [PRIO_W-1:0] level;
    logic              to_xfer;
    logic [CHAN_W-1:0] chan;
  } ietu_node_cfg_t;

  typedef struct packed {
    logic              word;
    logic              inc_dst;
    logic              continuous;
  } ietu_chan_cfg_t;

  typedef struct packed {
    logic              valid;
    logic              word;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic [CHAN_W-1:0] chan;
  } ietu_xfer_t;

  typedef struct packed {
    logic              valid;
    logic              exception;
    logic [NUM_W-1:0]  number;
    logic [VEC_W-1:0]  vector;
    logic [PRIO_W-1:0] level;
  } ietu_service_t;

endpackage : ietu_pkg

// >>> rtl/ietu_top.sv
`timescale 1ns/1ps
module ietu_top
  import ietu_pkg::*;
#(
  parameter int N_EXT = NEXT
) (
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire logic [NSRC-1:0]           periph_req,
  input  wire logic [N_EXT-1:0]          ext_in,
  input  wire logic [2*N_EXT-1:0]        edge_sel,
  input  wire ietu_node_cfg_t [NSRC-1:0] node_cfg,
  input  wire logic [NSRC-1:0]           sw_flag_set,
  input  wire logic [NSRC-1:0]           sw_flag_clr,
  input  wire ietu_chan_cfg_t [NCHAN-1:0] chan_cfg,
  input  wire logic [NCHAN-1:0]          chan_load,
  input  wire logic [ADDR_W-1:0]         load_src,
  input  wire logic [ADDR_W-1:0]         load_dst,
  input  wire logic [CNT_W-1:0]          load_cnt,
  input  wire logic                      xfer_done,
  input  wire logic                      sw_trap,
  input  wire logic [NUM_W-1:0]          sw_trap_num,
  input  wire logic                      cpu_ack,
  input  wire logic                      svc_return,
  input  wire logic [PRIO_W-1:0]         cpu_level,
  input  wire logic                      nmi_in,
  input  wire logic [CLSB_LO-1:0]        unused_b,
  input  wire logic [EXF_W-CLSB_LO-1:0]  class_b_in,
  input  wire logic                      stack_access,
  input  wire logic [ADDR_W-1:0]         stack_pointer,
  input  wire logic [ADDR_W-1:0]         stack_overflow_limit,
  input  wire logic [ADDR_W-1:0]         stack_underflow_limit,
  input  wire logic [EXF_W-1:0]          exf_clr,
  output ietu_service_t                  svc_q,
  output ietu_xfer_t                     xfer_q,
  output logic [NSRC-1:0]                request_flag_q,
  output logic [EXF_W-1:0]               exception_flag_register_q,
  output logic                           in_exception_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Fast external edge detection
  logic [N_EXT-1:0] ext_q;
  logic [N_EXT-1:0] ext_edge;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      ext_q <= '0;
    else
      ext_q <= ext_in;
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_EXT; gi++)
    begin : g_edge
      logic rise;
      logic fall;
      assign rise = ext_in[gi] & ~ext_q[gi];
      assign fall = ~ext_in[gi] & ext_q[gi];
      assign ext_edge[gi] = (edge_sel[2*gi +: 2] == EDGE_RISE) ? rise :
                            (edge_sel[2*gi +: 2] == EDGE_FALL) ? fall :
                            (edge_sel[2*gi +: 2] == EDGE_BOTH) ? (rise | fall) : 1'b0;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Request flags
  logic [NSRC-1:0] hw_set;
  logic [NSRC-1:0] grant_clr;
  logic [NSRC-1:0] cnt_zero_set;

  always_comb
  begin
    hw_set = periph_req | cnt_zero_set;
    hw_set[N_EXT-1:0] = hw_set[N_EXT-1:0] | ext_edge;
  end

  // software set counts as real request
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      request_flag_q <= '0;
    else
      request_flag_q <= (request_flag_q & ~sw_flag_clr & ~grant_clr) | hw_set | sw_flag_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration
  logic              win_valid;
  logic [4:0]        win_idx;
  logic [PRIO_W-1:0] win_lvl;

  // highest level, lowest index on tie
  always_comb
  begin
    win_valid = 1'b0;
    win_idx   = '0;
    win_lvl   = '0;
    for (int i = 0; i < NSRC; i++)
    begin
      if (request_flag_q[i] && node_cfg[i].enable && (!win_valid || node_cfg[i].level > win_lvl))
      begin
        win_valid = 1'b1;
        win_idx   = 5'(i);
        win_lvl   = node_cfg[i].level;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exception flags and stack check
  logic [EXF_W-1:0] exf_set;
  logic             sto_hit;
  logic             stu_hit;

  assign sto_hit = stack_access && (stack_pointer < stack_overflow_limit);
  assign stu_hit = stack_access && (stack_pointer > stack_underflow_limit);

  always_comb
  begin
    exf_set = '0;
    exf_set[EXF_NMI] = nmi_in;
    exf_set[EXF_STO] = sto_hit;
    exf_set[EXF_STU] = stu_hit;
    exf_set[EXF_W-1:CLSB_LO] = class_b_in;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      exception_flag_register_q <= '0;
    else
      exception_flag_register_q <= (exception_flag_register_q & ~exf_clr) | exf_set;
  end

  // Exception priority: NMI, overflow, underflow, then class B
  // Flags only record; each event arms one service, else a kept flag re-traps after return
  logic              exc_pend;
  logic [NUM_W-1:0]  exc_num;
  logic [1:0]        exc_rank;
  logic [EXF_W-1:0]  exc_req_q;
  logic [EXF_W-1:0]  exc_hit;

  always_comb
  begin
    exc_pend = |exc_req_q;
    exc_num  = NUM_CLSB;
    exc_rank = 2'h0;
    exc_hit  = '0;
    if (exc_req_q[EXF_NMI])
    begin
      exc_num  = NUM_NMI;
      exc_rank = 2'h3;
      exc_hit[EXF_NMI] = 1'b1;
    end
    else if (exc_req_q[EXF_STO])
    begin
      exc_num  = NUM_STO;
      exc_rank = 2'h2;
      exc_hit[EXF_STO] = 1'b1;
    end
    else if (exc_req_q[EXF_STU])
    begin
      exc_num  = NUM_STU;
      exc_rank = 2'h1;
      exc_hit[EXF_STU] = 1'b1;
    end
    else
      exc_hit[EXF_W-1:CLSB_LO] = '1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Service sequencing
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_XFER} ietu_state_t;
  ietu_state_t state_q;
  logic [1:0]  active_rank_q;
  logic        exc_taken;
  logic [ADDR_W-1:0] src_q [NCHAN];
  logic [ADDR_W-1:0] dst_q [NCHAN];
  logic [CNT_W-1:0]  cnt_q [NCHAN];

  // only a higher-ranked exception preempts another
  // exception is not gated by any enable
  assign exc_taken = exc_pend && (state_q == ST_IDLE) && !svc_q.valid &&
                     (!in_exception_q || exc_rank > active_rank_q);

  // Set wins: an event in the taking cycle arms a fresh service
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      exc_req_q <= '0;
    else
      exc_req_q <= (exc_req_q & ~({EXF_W{exc_taken}} & exc_hit)) | exf_set;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q        <= ST_IDLE;
      svc_q          <= '0;
      xfer_q         <= '0;
      in_exception_q <= 1'b0;
      active_rank_q  <= '0;
    end
    else
    begin
      xfer_q.valid <= 1'b0;
      if (cpu_ack)
        svc_q.valid <= 1'b0;
      if (svc_return)
        in_exception_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (exc_taken)
          begin
            // class A and class B vectors
            // vector is four times the number
            svc_q <= '{1'b1, 1'b1, exc_num, {exc_num, 2'b00}, {PRIO_W{1'b1}}};
            in_exception_q <= 1'b1;
            active_rank_q  <= exc_rank;
          end
          else if (sw_trap && !svc_q.valid)
          begin
            // software trap at its own vector
            svc_q <= '{1'b1, 1'b0, sw_trap_num, {sw_trap_num, 2'b00}, cpu_level};
          end
          else if (win_valid && !in_exception_q && !svc_q.valid && win_lvl > cpu_level)
          begin
            if (node_cfg[win_idx].to_xfer && cnt_q[node_cfg[win_idx].chan] != '0)
            begin
              xfer_q <= '{1'b1, chan_cfg[node_cfg[win_idx].chan].word,
                          src_q[node_cfg[win_idx].chan], dst_q[node_cfg[win_idx].chan],
                          node_cfg[win_idx].chan};
              state_q <= ST_XFER;
            end
            else
            begin
              // vector presented the cycle after arbitration, ahead of LAT_MIN_CLK
              svc_q <= '{1'b1, 1'b0, SRC_NUM[win_idx*NUM_W +: NUM_W],
                         {SRC_NUM[win_idx*NUM_W +: NUM_W], 2'b00}, win_lvl};
              state_q <= ST_WAIT;
            end
          end
        end
        ST_WAIT:
        begin
          // Hold off re-arbitration until the CPU takes the vector
          if (cpu_ack || !svc_q.valid)
            state_q <= ST_IDLE;
        end
        ST_XFER:
        begin
          if (xfer_done)
            state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Flag cleared when its request is granted
  always_comb
  begin
    grant_clr = '0;
    if (state_q == ST_IDLE && !exc_taken && !(sw_trap && !svc_q.valid) && win_valid &&
        !in_exception_q && !svc_q.valid && win_lvl > cpu_level)
      grant_clr[win_idx] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event transfer channels

  generate
    for (gi = 0; gi < NCHAN; gi++)
    begin : g_chan
      logic done;
      logic [ADDR_W-1:0] step;
      assign done = (state_q == ST_XFER) && xfer_done && (xfer_q.chan == CHAN_W'(gi));
      assign step = chan_cfg[gi].word ? ADDR_W'(2) : ADDR_W'(1);
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          src_q[gi] <= '0;
          dst_q[gi] <= '0;
          cnt_q[gi] <= '0;
        end
        else if (chan_load[gi])
        begin
          src_q[gi] <= load_src;
          dst_q[gi] <= load_dst;
          cnt_q[gi] <= load_cnt;
        end
        else if (done)
        begin
          // bump one pointer by operand size
          if (chan_cfg[gi].inc_dst)
            dst_q[gi] <= dst_q[gi] + step;
          else
            src_q[gi] <= src_q[gi] + step;
          if (!chan_cfg[gi].continuous)
            cnt_q[gi] <= cnt_q[gi] - CNT_W'(1);
        end
      end
    end
  endgenerate

  // count hitting zero re-raises the source as an interrupt
  logic [4:0] xfer_src_q;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      xfer_src_q <= '0;
    else if (state_q == ST_IDLE && grant_clr != '0)
      xfer_src_q <= win_idx;
  end

  always_comb
  begin
    cnt_zero_set = '0;
    if (state_q == ST_XFER && xfer_done && !chan_cfg[xfer_q.chan].continuous &&
        cnt_q[xfer_q.chan] == CNT_W'(1))
      cnt_zero_set[xfer_src_q] = 1'b1;
  end

endmodule : ietu_top

// >>> dv/ietu_checker.sv
`timescale 1ns/1ps
module ietu_checker
  import ietu_pkg::*;
#(
  parameter int N_EXT = NEXT
) (
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic              nmi_in,
  input wire logic              svc_return,
  input wire logic              stack_access,
  input wire logic [ADDR_W-1:0] stack_pointer,
  input wire logic [ADDR_W-1:0] stack_overflow_limit,
  input wire logic [ADDR_W-1:0] stack_underflow_limit,
  input wire ietu_service_t     svc_q,
  input wire ietu_xfer_t        xfer_q,
  input wire logic [EXF_W-1:0]  exception_flag_register_q,
  input wire logic              in_exception_q
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  vec_four_a: assert property (svc_q.valid |-> svc_q.vector == {svc_q.number, 2'h0})
    else $error("vector not four times number");
  xfer_pulse_a: assert property (xfer_q.valid |=> !xfer_q.valid)
    else $error("transfer strobe too long");
  xfer_exc_a: assert property (in_exception_q && $past(in_exception_q) |-> !xfer_q.valid)
    else $error("transfer inside exception service");
  exc_end_a: assert property ($fell(in_exception_q) |-> $past(svc_return))
    else $error("exception service left without return");
  nmi_flag_a: assert property (nmi_in |=> exception_flag_register_q[EXF_NMI])
    else $error("nmi flag not set");
  nmi_vec_a: assert property (nmi_in && !in_exception_q && !svc_q.valid |->
    ##[1:2] (svc_q.valid && svc_q.exception && svc_q.vector == 9'h008)) else $error("nmi not served");
  stk_over_a: assert property (stack_access && stack_pointer < stack_overflow_limit
    |=> exception_flag_register_q[EXF_STO]) else $error("overflow missed");
  stk_under_a: assert property (stack_access && stack_pointer > stack_underflow_limit
    |=> exception_flag_register_q[EXF_STU]) else $error("underflow missed");
  cover property ($rose(xfer_q.valid));
  cover property (svc_q.valid && svc_q.exception);
  cover property (svc_q.valid && !svc_q.exception);
endmodule : ietu_checker

bind ietu_top ietu_checker #(.N_EXT(N_EXT)) ietu_checker_i (.clock, .rst_b, .nmi_in, .svc_return,
  .stack_access, .stack_pointer, .stack_overflow_limit, .stack_underflow_limit, .svc_q, .xfer_q,
  .exception_flag_register_q, .in_exception_q);

// >>> dv/ietu_cpu_model.sv
`timescale 1ns/1ps
module ietu_cpu_model
  import ietu_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  wire ietu_service_t svc_q,
  input  wire ietu_xfer_t    xfer_q,
  input  wire logic          slow,
  input  wire logic          hold_exc,
  output logic               cpu_ack,
  output logic               xfer_done,
  output logic               svc_return
);
  logic [2:0] wait_q;
  logic       exc_q;
  ////////////////////////////////////////
  // Slow mode keeps a service pending so the hold of svc_q is exercised
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {cpu_ack, xfer_done, svc_return, exc_q, wait_q} <= '0;
    end
    else
    begin
      cpu_ack    <= 1'b0;
      svc_return <= 1'b0;
      xfer_done  <= xfer_q.valid;
      if (svc_q.valid && !cpu_ack)
      begin
        wait_q <= wait_q + 3'h1;
        if (wait_q >= (slow ? 3'h4 : 3'h0))
        begin
          cpu_ack <= 1'b1;
          wait_q  <= 3'h0;
          exc_q   <= svc_q.exception;
        end
      end
      else if (exc_q && !hold_exc && !cpu_ack)
      begin
        svc_return <= 1'b1;
        exc_q      <= 1'b0;
      end
    end
  end
endmodule : ietu_cpu_model

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench
  import ietu_pkg::*;
();
  logic                       clock, rst_b, sw_trap, nmi_in, stack_access, slow, hold_exc;
  logic                       cpu_ack, xfer_done, svc_return, in_exception_q;
  logic [NSRC-1:0]            periph_req, sw_flag_set, sw_flag_clr, request_flag_q;
  logic [NEXT-1:0]            ext_in;
  logic [2*NEXT-1:0]          edge_sel;
  ietu_node_cfg_t [NSRC-1:0]  node_cfg;
  ietu_chan_cfg_t [NCHAN-1:0] chan_cfg;
  logic [NCHAN-1:0]           chan_load;
  logic [ADDR_W-1:0]          load_src, load_dst, stack_pointer, stack_overflow_limit, stack_underflow_limit;
  logic [CNT_W-1:0]           load_cnt;
  logic [NUM_W-1:0]           sw_trap_num;
  logic [PRIO_W-1:0]          cpu_level;
  logic [EXF_W-CLSB_LO-1:0]   class_b_in;
  logic [EXF_W-1:0]           exf_clr, exception_flag_register_q;
  ietu_service_t              svc_q;
  ietu_xfer_t                 xfer_q;
  int                         fail_count, checks;
  ////////////////////////////////////////
  ietu_top ietu_top_i (.clock, .rst_b, .periph_req, .ext_in, .edge_sel, .node_cfg, .sw_flag_set, .sw_flag_clr,
    .chan_cfg, .chan_load, .load_src, .load_dst, .load_cnt, .xfer_done, .sw_trap, .sw_trap_num, .cpu_ack,
    .svc_return, .cpu_level, .nmi_in, .unused_b(3'h0), .class_b_in, .stack_access, .stack_pointer,
    .stack_overflow_limit, .stack_underflow_limit, .exf_clr, .svc_q, .xfer_q, .request_flag_q,
    .exception_flag_register_q, .in_exception_q);
  ietu_cpu_model ietu_cpu_model_i (.clock, .rst_b, .svc_q, .xfer_q, .slow, .hold_exc, .cpu_ack, .xfer_done,
    .svc_return);
  ////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task req(input logic [NSRC-1:0] m);
    periph_req <= m;
    tick(1);
    periph_req <= '0;
  endtask : req
  task stk(input logic [15:0] sp);
    stack_pointer <= sp;
    stack_access  <= 1'b1;
    tick(1);
    stack_access <= 1'b0;
    tick(1);
  endtask : stk
  task clr5;
    sw_flag_clr[5] <= 1'b1;
    tick(1);
    sw_flag_clr <= '0;
    tick(1);
  endtask : clr5
  task quiet;
    repeat (LAT_MAX_CLK)
    begin
      tick(1);
      chk(16'(svc_q.valid), 16'h0, "quiet");
    end
  endtask : quiet
  // Latency counts from the edge after the request pulse
  task wait_svc(input logic [NUM_W-1:0] num, input logic exc);
    int n;
    n = 0;
    while (svc_q.valid !== 1'b1 && n < 30)
    begin
      tick(1);
      n++;
    end
    chk(16'(n <= LAT_MAX_CLK), 16'h1, "late");
    chk(16'(svc_q.number), 16'(num), "num");
    chk(16'(svc_q.vector), {7'h0, num, 2'h0}, "vec");
    chk(16'(svc_q.exception), 16'(exc), "kind");
    while ((svc_q.valid === 1'b1 || (in_exception_q === 1'b1 && !hold_exc)) && n < 60)
    begin
      tick(1);
      n++;
    end
  endtask : wait_svc
  task wait_xfer(input logic [15:0] src, input logic [15:0] dst, input logic word, input logic [2:0] ch);
    int n;
    n = 0;
    while (xfer_q.valid !== 1'b1 && n < 30)
    begin
      tick(1);
      n++;
    end
    chk(xfer_q.src, src, "src");
    chk(xfer_q.dst, dst, "dst");
    chk(16'({xfer_q.valid, xfer_q.word, xfer_q.chan, svc_q.valid}), 16'({1'b1, word, ch, 1'b0}), "xfer");
    tick(2);
  endtask : wait_xfer
  task end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Run needs under a thousand cycles
  initial
  begin
    #100000;
    fail_count++;
    end_sim();
  end
  initial
  begin
    {periph_req, ext_in, edge_sel, node_cfg, sw_flag_set, sw_flag_clr, chan_cfg, chan_load, load_src} = '0;
    {load_dst, load_cnt, sw_trap, sw_trap_num, cpu_level, nmi_in, class_b_in, stack_access, exf_clr} = '0;
    {stack_pointer, slow, hold_exc, rst_b, fail_count, checks} = '0;
    stack_overflow_limit  = 16'h0100;
    stack_underflow_limit = 16'h0800;
    tick(8);
    rst_b <= 1'b1;
    tick(2);
    for (int i = 0; i < NSRC; i++)
      node_cfg[i] <= '{i != 5, (i == 0) ? 4'h5 : (i == 4) ? 4'hA : (i == 3 || i == 14) ? 4'h9 : 4'h2,
                       i == 8 || i == 9, (i == 9) ? 3'h5 : 3'h2};
    slow <= 1'b1;
    req(20'h04001);
    wait_svc(7'h47, 1'b0);
    wait_svc(7'h19, 1'b0);
    slow <= 1'b0;
    req(20'h00006);
    wait_svc(7'h1A, 1'b0);
    wait_svc(7'h1B, 1'b0);
    cpu_level <= 4'h9;
    req(20'h00008);
    quiet();
    chk(16'(request_flag_q[3]), 16'h1, "pend");
    req(20'h00010);
    wait_svc(7'h1D, 1'b0);
    cpu_level <= 4'h0;
    wait_svc(7'h1C, 1'b0);
    for (int m = 0; m < 4; m++)
    begin
      edge_sel[11:10] <= 2'(m);
      tick(1);
      ext_in[5] <= 1'b1;
      tick(3);
      chk(16'(request_flag_q[5]), 16'(m % 2), "rise");
      clr5();
      ext_in[5] <= 1'b0;
      tick(3);
      chk(16'(request_flag_q[5]), 16'(m / 2), "fall");
      clr5();
    end
    sw_flag_set[19] <= 1'b1;
    tick(1);
    sw_flag_set <= '0;
    wait_svc(7'h2F, 1'b0);
    sw_trap     <= 1'b1;
    sw_trap_num <= 7'h7F;
    tick(1);
    sw_trap <= 1'b0;
    wait_svc(7'h7F, 1'b0);
    chan_cfg[2] <= '{1'b1, 1'b0, 1'b0};
    chan_cfg[5] <= '{1'b0, 1'b1, 1'b1};
    chan_load   <= 8'h04;
    {load_src, load_dst, load_cnt} <= {16'h1000, 16'h2000, 8'h02};
    tick(1);
    chan_load <= 8'h20;
    {load_src, load_dst, load_cnt} <= {16'h4000, 16'h3000, 8'h01};
    tick(1);
    chan_load <= '0;
    req(20'h00100);
    wait_xfer(16'h1000, 16'h2000, 1'b1, 3'h2);
    req(20'h00100);
    wait_xfer(16'h1002, 16'h2000, 1'b1, 3'h2);
    wait_svc(7'h23, 1'b0);
    req(20'h00200);
    wait_xfer(16'h4000, 16'h3000, 1'b0, 3'h5);
    req(20'h00200);
    wait_xfer(16'h4000, 16'h3001, 1'b0, 3'h5);
    hold_exc <= 1'b1;
    nmi_in   <= 1'b1;
    tick(1);
    nmi_in <= 1'b0;
    wait_svc(NUM_NMI, 1'b1);
    chk(16'(in_exception_q), 16'h1, "inexc");
    req(20'h04000);
    quiet();
    stk(16'h00FF);
    quiet();
    hold_exc <= 1'b0;
    wait_svc(NUM_STO, 1'b1);
    wait_svc(7'h47, 1'b0);
    for (int k = 0; k < 5; k++)
    begin
      class_b_in <= 5'(1 << k);
      tick(1);
      class_b_in <= '0;
      wait_svc(NUM_CLSB, 1'b1);
    end
    chk(16'(exception_flag_register_q), 16'h00FB, "flags");
    exf_clr <= 8'hFF;
    tick(1);
    exf_clr <= '0;
    stk(16'h0100);
    stk(16'h0800);
    chk(16'(exception_flag_register_q), 16'h0000, "bound");
    stk(16'h00FF);
    wait_svc(NUM_STO, 1'b1);
    stk(16'h0801);
    wait_svc(NUM_STU, 1'b1);
    chk(16'(exception_flag_register_q), 16'h0006, "stack");
    end_sim();
  end
endmodule : testbench
